// *** lcd_bias_pkg.sv ***
// shared constants and types for the lcd bias regulator control
package lcd_bias_pkg;

	// register map (byte addresses)
	localparam logic [31:0] REG_CTRL_OFFSET = 32'h0000_0000;

	// control register field positions
	localparam int CKSEL_LSB  = 0;
	localparam int THIRD_BIAS_SELECT_BIT = 2;
	localparam int BIAS_LSB   = 3;
	localparam int PUMP_ENABLE_BIT   = 6;
	localparam int RSVD_BIT   = 7;

	// reset value and writable bits of the control register
	localparam logic [7:0] CTRL_RESET = 8'h3c;
	localparam logic [7:0] CTRL_WMASK = 8'h7f;

	// fixed prescaler on the fast oscillator branch
	localparam int PRESCALE_DIV = 256;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// regulator clock select codes
	localparam logic [1:0] CLK_OFF       = 2'h0;
	localparam logic [1:0] CLK_SECONDARY = 2'h1;
	localparam logic [1:0] CLK_FAST      = 2'h2;
	localparam logic [1:0] CLK_RC        = 2'h3;

	// bias generation configurations
	typedef enum logic [1:0] {
		CFG_BOOST     = 2'b00,
		CFG_UNBOOST   = 2'b01,
		CFG_LADDER_REF = 2'b10,
		CFG_LADDER    = 2'b11
	} config_type;

endpackage

// *** regulator_clock_gen.sv ***
// charge pump clock selection, prescaler and gating
`timescale 1ns/1ps
module regulator_clock_gen #(
	parameter int PRESCALE = lcd_bias_pkg::PRESCALE_DIV
) (
	input  wire logic       aclk,                     // system clock
	input  wire logic       aresetn,                  // sync reset, low
	input  wire logic [1:0] clock_select,             // source code
	input  wire logic       gate_on,                  // pass clock out
	input  wire logic       internal_rc_clock,        // rc source level
	input  wire logic       internal_fast_oscillator, // fast osc level
	input  wire logic       secondary_oscillator,     // secondary level
	output logic            pump_clock                // gated pump clock
);
	import lcd_bias_pkg::*;

	localparam int HALF = PRESCALE / 2;
	localparam int CW   = (HALF > 1) ? $clog2(HALF) : 1;

	if (PRESCALE < 4 || (PRESCALE % 2) != 0) begin : g_bad_prescale
		$error("PRESCALE must be even and at least 4");
	end

	logic          fast_prev_ff;
	logic [CW-1:0] cnt_ff;
	logic          div_ff;
	logic          pump_clock_ff;
	wire           fast_rise;
	wire           cnt_wrap;
	wire           sel_clk;

	// edge of the fast source; inputs are synchronous to aclk
	assign fast_rise = internal_fast_oscillator & ~fast_prev_ff;
	assign cnt_wrap  = (cnt_ff == CW'(HALF - 1));

	// source mux, off code gives a quiet line
	assign sel_clk = (clock_select == CLK_RC)        ? internal_rc_clock :
	                 (clock_select == CLK_FAST)      ? div_ff :
	                 (clock_select == CLK_SECONDARY) ? secondary_oscillator :
	                 1'b0;

	// divide fast source: toggle every half period of the prescale
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fast_prev_ff <= 1'b0;
			cnt_ff       <= '0;
			div_ff       <= 1'b0;
		end else begin
			fast_prev_ff <= internal_fast_oscillator;
			if (fast_rise) begin
				cnt_ff <= cnt_wrap ? '0 : cnt_ff + 1'b1;
				div_ff <= cnt_wrap ? ~div_ff : div_ff;
			end
		end
	end

	// gate held low while the pump is not in use
	always_ff @(posedge aclk) begin
		if (!aresetn)
			pump_clock_ff <= 1'b0;
		else
			pump_clock_ff <= gate_on & sel_clk;
	end

	assign pump_clock = pump_clock_ff;

endmodule

// *** lcd_bias_regulator_control.sv ***
// lcd bias regulator control register and configuration decode
//
// Summary of operation
// - clock select picks pump source or off
// - bit 6 turns charge pump on
// - three-bit code picks one of eight peaks
// - bit 2 selects third bias, else static
// - top bit reads zero, writes ignored
// - nonzero clock with pump gives boosted config
// - nonzero clock without pump gives unboosted config
// - zero clock with pump keeps reference only
// - zero clock, no pump disables all, grounds
// - reference ladder config frees flyback pins
// - disabled config ignores bias level code
// - fast oscillator divided by fixed 256
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module lcd_bias_regulator_control #(
	parameter int ADDR_W   = 4,                         // axi address bits
	parameter int PRESCALE = lcd_bias_pkg::PRESCALE_DIV // fast osc divider
) (
	input  wire logic              aclk,          // system clock
	input  wire logic              aresetn,       // sync reset, low
	input  wire logic [ADDR_W-1:0] awaddr,        // write address
	input  wire logic              awvalid,       // write addr valid
	output logic                   awready,       // write addr ready
	input  wire logic [31:0]       wdata,         // write data
	input  wire logic [3:0]        wstrb,         // write byte strobes
	input  wire logic              wvalid,        // write data valid
	output logic                   wready,        // write data ready
	output logic [1:0]             bresp,         // write response
	output logic                   bvalid,        // write resp valid
	input  wire logic              bready,        // write resp ready
	input  wire logic [ADDR_W-1:0] araddr,        // read address
	input  wire logic              arvalid,       // read addr valid
	output logic                   arready,       // read addr ready
	output logic [31:0]            rdata,         // read data
	output logic [1:0]             rresp,         // read response
	output logic                   rvalid,        // read data valid
	input  wire logic              rready,        // read data ready
	input  wire logic              internal_rc_clock,        // rc source
	input  wire logic              internal_fast_oscillator, // fast osc
	input  wire logic              secondary_oscillator,     // secondary
	output logic [1:0]             regulator_clock_select,   // clock field
	output logic                   pump_enable,              // pump bit
	output logic [2:0]             bias_level,               // peak code
	output logic                   third_bias_select,        // 1/3 bias
	output logic                   boosted_regulator_config,     // m0
	output logic                   unboosted_regulator_config,   // m1
	output logic                   ladder_with_reference_config, // m2
	output logic                   ladder_only_config,           // m3
	output logic                   regulator_enable,   // regulator on
	output logic                   reference_enable,   // reference on
	output logic                   bias_bottom_grounded, // bottom to gnd
	output logic [2:0]             contrast_code,      // applied offset
	output logic                   flyback_pins_released, // pins as gpio
	output logic                   pump_clock          // gated pump clock
);
	import lcd_bias_pkg::*;

	if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must be between 3 and 32");
	end

	// word decode, shared by write and read paths
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:2] == REG_CTRL_OFFSET[ADDR_W-1:2];
	endfunction

	// configuration from clock select and pump bit
	function automatic config_type cfg_decode(input logic [7:0] r);
		logic clk_on;
		clk_on = (r[CKSEL_LSB +: 2] != CLK_OFF);
		if (clk_on && r[PUMP_ENABLE_BIT])
			return CFG_BOOST;
		else if (clk_on)
			return CFG_UNBOOST;
		else if (r[PUMP_ENABLE_BIT])
			return CFG_LADDER_REF;
		else
			return CFG_LADDER;
	endfunction

	logic [7:0]        ctrl_ff;
	logic              aw_got_ff;
	logic              w_got_ff;
	logic [ADDR_W-1:0] awaddr_ff;
	logic [7:0]        wdata_ff;
	logic              wstrb0_ff;
	logic              awready_ff;
	logic              wready_ff;
	logic              bvalid_ff;
	logic [1:0]        bresp_ff;
	logic              arready_ff;
	logic              rvalid_ff;
	logic [31:0]       rdata_ff;
	logic [1:0]        rresp_ff;
	logic [3:0]        cfg_onehot_ff;
	logic              reg_en_ff;
	logic              ref_en_ff;
	logic              grounded_ff;
	logic [2:0]        contrast_ff;
	logic              released_ff;
	config_type        nxt_cfg;

	wire aw_hs;
	wire w_hs;
	wire ar_hs;
	wire do_write;
	wire write_hit;
	wire nxt_aw_got;
	wire nxt_w_got;
	wire nxt_bvalid;
	wire nxt_rvalid;
	wire pump_gate;

	// handshakes and write sequencing
	assign aw_hs      = awvalid & awready_ff;
	assign w_hs       = wvalid & wready_ff;
	assign ar_hs      = arvalid & arready_ff;
	assign do_write   = aw_got_ff & w_got_ff & ~bvalid_ff;
	assign write_hit  = do_write & addr_hit(awaddr_ff) & wstrb0_ff;
	assign nxt_aw_got = (aw_got_ff | aw_hs) & ~do_write;
	assign nxt_w_got  = (w_got_ff | w_hs) & ~do_write;
	assign nxt_bvalid = do_write | (bvalid_ff & ~bready);
	assign nxt_rvalid = ar_hs | (rvalid_ff & ~rready);

	// address and data are taken in either order, held until both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff  <= 1'b0;
			w_got_ff   <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
		end else begin
			aw_got_ff  <= nxt_aw_got;
			w_got_ff   <= nxt_w_got;
			awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
			wready_ff  <= ~nxt_w_got & ~nxt_bvalid;
			bvalid_ff  <= nxt_bvalid;
		end
	end

	// payload capture; unmapped words get slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_ff <= '0;
			wdata_ff  <= 8'h00;
			wstrb0_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else begin
			if (aw_hs)
				awaddr_ff <= awaddr;
			if (w_hs) begin
				wdata_ff  <= wdata[7:0];
				wstrb0_ff <= wstrb[0];
			end
			if (do_write)
				bresp_ff <= addr_hit(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// control register; only the low byte lane carries it
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctrl_ff <= CTRL_RESET;
		else if (write_hit)
			ctrl_ff <= wdata_ff & CTRL_WMASK;
	end

	// read channel; one read outstanding at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= RESP_OKAY;
		end else begin
			arready_ff <= ~nxt_rvalid;
			rvalid_ff  <= nxt_rvalid;
			if (ar_hs) begin
				rdata_ff <= addr_hit(araddr) ?
				            {24'h00_0000, ctrl_ff & CTRL_WMASK} :
				            32'h0000_0000;
				rresp_ff <= addr_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// bias configuration decode from the stored fields
	assign nxt_cfg   = cfg_decode(ctrl_ff);
	assign pump_gate = (nxt_cfg == CFG_BOOST);

	// registered so every output leaves from a flop; costs one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_onehot_ff <= 4'h8;
			reg_en_ff     <= 1'b0;
			ref_en_ff     <= 1'b0;
			grounded_ff   <= 1'b1;
			contrast_ff   <= 3'h0;
			released_ff   <= 1'b0;
		end else begin
			cfg_onehot_ff <= 4'h1 << nxt_cfg;
			reg_en_ff     <= (nxt_cfg == CFG_BOOST) ||
			                 (nxt_cfg == CFG_UNBOOST);
			ref_en_ff     <= (nxt_cfg != CFG_LADDER);
			grounded_ff   <= (nxt_cfg == CFG_LADDER);
			contrast_ff   <= (nxt_cfg == CFG_LADDER) ? 3'h0 :
			                 ctrl_ff[BIAS_LSB +: 3];
			released_ff   <= (nxt_cfg == CFG_LADDER_REF);
		end
	end

	regulator_clock_gen #(
		.PRESCALE (PRESCALE)
	) u_clock_gen (
		.aclk                     (aclk),
		.aresetn                  (aresetn),
		.clock_select             (ctrl_ff[CKSEL_LSB +: 2]),
		.gate_on                  (pump_gate),
		.internal_rc_clock        (internal_rc_clock),
		.internal_fast_oscillator (internal_fast_oscillator),
		.secondary_oscillator     (secondary_oscillator),
		.pump_clock               (pump_clock)
	);

	// bus outputs
	assign awready = awready_ff;
	assign wready  = wready_ff;
	assign bvalid  = bvalid_ff;
	assign bresp   = bresp_ff;
	assign arready = arready_ff;
	assign rvalid  = rvalid_ff;
	assign rdata   = rdata_ff;
	assign rresp   = rresp_ff;

	// field and configuration outputs
	assign regulator_clock_select       = ctrl_ff[CKSEL_LSB +: 2];
	assign pump_enable                  = ctrl_ff[PUMP_ENABLE_BIT];
	assign bias_level                   = ctrl_ff[BIAS_LSB +: 3];
	assign third_bias_select            = ctrl_ff[THIRD_BIAS_SELECT_BIT];
	assign boosted_regulator_config     = cfg_onehot_ff[CFG_BOOST];
	assign unboosted_regulator_config   = cfg_onehot_ff[CFG_UNBOOST];
	assign ladder_with_reference_config = cfg_onehot_ff[CFG_LADDER_REF];
	assign ladder_only_config           = cfg_onehot_ff[CFG_LADDER];
	assign regulator_enable             = reg_en_ff;
	assign reference_enable             = ref_en_ff;
	assign bias_bottom_grounded         = grounded_ff;
	assign contrast_code                = contrast_ff;
	assign flyback_pins_released        = released_ff;

	// checks on the bus answers, the stored fields and the decoded configuration
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_write_both;
		aw_got_ff && w_got_ff && !bvalid_ff;
	endsequence

	sequence s_write_answer;
		bvalid_ff [*1] ##0 (bresp_ff == RESP_OKAY || bresp_ff == RESP_SLVERR);
	endsequence

	a_reserved_reads_zero: assert property (
		rvalid_ff |-> (rdata_ff[31:RSVD_BIT] == '0))
		else $error("reserved control bits read nonzero");

	a_write_lands: assert property (
		write_hit |=> ctrl_ff == ($past(wdata_ff) & CTRL_WMASK))
		else $error("control write not stored");

	a_write_answer: assert property (
		s_write_both |=> s_write_answer)
		else $error("write response missing");

	a_boost_config: assert property (
		boosted_regulator_config ==
		($past(ctrl_ff[CKSEL_LSB +: 2]) != CLK_OFF && $past(ctrl_ff[PUMP_ENABLE_BIT])))
		else $error("boosted configuration mismatch");

	a_unboost_config: assert property (
		unboosted_regulator_config == ($past(ctrl_ff[CKSEL_LSB +: 2]) !=
		CLK_OFF && !$past(ctrl_ff[PUMP_ENABLE_BIT])) && (!unboosted_regulator_config
		|| regulator_enable && !$past(pump_gate)))
		else $error("unboosted configuration mismatch");

	a_reference_only: assert property (
		ladder_with_reference_config |-> reference_enable &&
		!regulator_enable && !bias_bottom_grounded)
		else $error("reference not kept alone");

	a_full_disable: assert property (
		$past(ctrl_ff[CKSEL_LSB +: 2]) == CLK_OFF && !$past(ctrl_ff[PUMP_ENABLE_BIT])
		|-> ladder_only_config && !reference_enable && bias_bottom_grounded)
		else $error("disabled configuration not complete");

	a_pins_released: assert property (
		flyback_pins_released == ladder_with_reference_config)
		else $error("flyback pins release mismatch");

	a_contrast_ignored: assert property (
		ladder_only_config |-> contrast_code == 3'h0)
		else $error("contrast applied while disabled");

	a_pump_clock_idle: assert property (
		!$past(pump_gate) |-> !pump_clock)
		else $error("pump clock running while gated");

	a_read_answer: assert property (
		ar_hs |=> rvalid_ff && !arready_ff)
		else $error("read data not returned in one cycle");

endmodule

// *** test_lcd_bias_regulator_control.sv ***
// self-checking bench for the lcd bias regulator control block
`timescale 1ns/1ps
module test_lcd_bias_regulator_control;
	import lcd_bias_pkg::*;

	// short prescaler keeps the divided fast clock quick to observe
	localparam int PRESC = 4;

	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [3:0]  awaddr = 4'h0;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        wvalid = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready = 1'b0;
	logic [3:0]  araddr = 4'h0;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready = 1'b0;
	logic        internal_rc_clock = 1'b0;
	logic        internal_fast_oscillator = 1'b0;
	logic        secondary_oscillator = 1'b0;
	logic [1:0]  regulator_clock_select;
	logic        pump_enable;
	logic [2:0]  bias_level;
	logic        third_bias_select;
	logic        boosted_regulator_config;
	logic        unboosted_regulator_config;
	logic        ladder_with_reference_config;
	logic        ladder_only_config;
	logic        regulator_enable;
	logic        reference_enable;
	logic        bias_bottom_grounded;
	logic [2:0]  contrast_code;
	logic        flyback_pins_released;
	logic        pump_clock;
	logic [3:0]  lane_sel = 4'h1;
	int          miscompares = 0;
	int          cmp_count = 0;

	// 125 MHz system clock, fast source toggles every cycle
	always #4 aclk = ~aclk;
	always @(posedge aclk) internal_fast_oscillator <= ~internal_fast_oscillator;

	lcd_bias_regulator_control #(.ADDR_W(4), .PRESCALE(PRESC)) dut (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.internal_rc_clock(internal_rc_clock),
		.internal_fast_oscillator(internal_fast_oscillator),
		.secondary_oscillator(secondary_oscillator),
		.regulator_clock_select(regulator_clock_select),
		.pump_enable(pump_enable), .bias_level(bias_level),
		.third_bias_select(third_bias_select),
		.boosted_regulator_config(boosted_regulator_config),
		.unboosted_regulator_config(unboosted_regulator_config),
		.ladder_with_reference_config(ladder_with_reference_config),
		.ladder_only_config(ladder_only_config),
		.regulator_enable(regulator_enable),
		.reference_enable(reference_enable),
		.bias_bottom_grounded(bias_bottom_grounded),
		.contrast_code(contrast_code),
		.flyback_pins_released(flyback_pins_released),
		.pump_clock(pump_clock)
	);

	// verdict and end of run, also reached when a wait runs out
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_up;
		miscompares++;
		$display("wait limit reached at %0t", $time);
		conclude();
	endtask

	// reset is synchronous, so hold it across two edges
	task automatic do_reset;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		#1;
	endtask

	// one write; both channels offered together, each dropped when taken
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		logic aw_pend;
		logic w_pend;
		n = 0;
		aw_pend = 1'b1;
		w_pend = 1'b1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= lane_sel;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while ((aw_pend || w_pend) && n < 50) begin
			@(posedge aclk);
			n++;
			if (aw_pend && awready === 1'b1) begin
				aw_pend = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_pend && wready === 1'b1) begin
				w_pend = 1'b0;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1 && n < 50) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 50) give_up();
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	// one read; address held until taken, rready held until data seen
	task automatic axi_read(input logic [3:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (arready !== 1'b1 && n < 50);
		arvalid <= 1'b0;
		do begin
			@(posedge aclk);
			n++;
		end while (rvalid !== 1'b1 && n < 50);
		if (n >= 50) give_up();
		rready <= 1'b0;
		chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	// field and configuration outputs, not pump_clock, predicted from the control byte
	task automatic expect_outputs(input logic [7:0] v);
		logic        on;
		logic        off_all;
		logic        ref_only;
		logic [17:0] exp;
		logic [17:0] got;
		on = (v[1:0] != CLK_OFF);
		off_all = !on && !v[6];
		ref_only = !on && v[6];
		exp = {v[1:0], v[6], v[5:3], v[2], on && v[6], on && !v[6],
			ref_only, off_all, on, !off_all, off_all,
			off_all ? 3'h0 : v[5:3], ref_only};
		got = {regulator_clock_select, pump_enable, bias_level,
			third_bias_select, boosted_regulator_config,
			unboosted_regulator_config, ladder_with_reference_config,
			ladder_only_config, regulator_enable, reference_enable,
			bias_bottom_grounded, contrast_code, flyback_pins_released};
		chk({14'h0, got}, {14'h0, exp});
	endtask

	// write, read back without the top bit, then let the decode settle
	task automatic cfg_step(input logic [7:0] v);
		axi_write(4'h0, {24'h0, v}, RESP_OKAY);
		axi_read(4'h0, {24'h0, v & 8'h7f}, RESP_OKAY);
		repeat (2) @(posedge aclk);
		#1;
		expect_outputs(v & 8'h7f);
	endtask

	// chosen source driven with a pattern, the other with its inverse
	task automatic pump_follow(input logic [1:0] sel, input logic pmp);
		logic gate;
		logic pat;
		gate = (sel != CLK_OFF) && pmp;
		axi_write(4'h0, {24'h0, 1'b0, pmp, 3'h7, 1'b0, sel}, RESP_OKAY);
		for (int i = 0; i < 6; i++) begin
			pat = i[0];
			@(posedge aclk);
			internal_rc_clock <= (sel == CLK_SECONDARY) ? ~pat : pat;
			secondary_oscillator <= (sel == CLK_SECONDARY) ? pat : ~pat;
			@(posedge aclk);
			#1;
			chk({31'h0, pump_clock}, {31'h0, gate & pat});
		end
	endtask

	// fast source rises every 2 cycles, output flips every PRESC/2 rises
	task automatic fast_divide;
		logic last;
		int   n;
		axi_write(4'h0, 32'h0000_0042, RESP_OKAY);
		for (int k = 0; k < 3; k++) begin
			last = pump_clock;
			n = 0;
			do begin
				@(posedge aclk);
				#1;
				n++;
			end while (pump_clock === last && n < 50);
			if (n >= 50) give_up();
			if (k > 0) chk(32'(n), 32'(PRESC));
		end
	endtask

	// main sequence
	initial begin
		do_reset();
		expect_outputs(8'h3c);
		axi_read(4'h0, 32'h0000_003c, RESP_OKAY);
		cfg_step(8'hff);
		cfg_step(8'h41);
		cfg_step(8'h0e);
		cfg_step(8'h53);
		cfg_step(8'h1d);
		cfg_step(8'h64);
		cfg_step(8'h28);
		cfg_step(8'h72);
		// unmapped word: refused and register left alone
		axi_write(4'h4, 32'h0000_0001, RESP_SLVERR);
		axi_read(4'h0, 32'h0000_0072, RESP_OKAY);
		// low byte lane not strobed: answered okay, register kept
		lane_sel = 4'h0;
		axi_write(4'h0, 32'h0000_0011, RESP_OKAY);
		lane_sel = 4'h1;
		axi_read(4'h0, 32'h0000_0072, RESP_OKAY);
		axi_read(4'h8, 32'h0000_0000, RESP_SLVERR);
		pump_follow(CLK_RC, 1'b1);
		pump_follow(CLK_SECONDARY, 1'b1);
		pump_follow(CLK_RC, 1'b0);
		pump_follow(CLK_OFF, 1'b1);
		fast_divide();
		// reset in mid-run restores the defaults
		do_reset();
		expect_outputs(8'h3c);
		axi_read(4'h0, 32'h0000_003c, RESP_OKAY);
		conclude();
	end

endmodule
